// file: design/cvtpg_pkg.sv
/*
 Constants for the CSI-2 video test pattern generator: register map,
 field positions, reset values, packet codes, colours and timing.
 Assumes a 32-bit AXI4-Lite register bus and a 200 MHz core clock.
*/
package cvtpg_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CSI = 8'h04;
   localparam logic [7:0] OFF_LINE_SIZE = 8'h08;
   localparam logic [7:0] OFF_BAR_SIZE = 8'h0C;
   localparam logic [7:0] OFF_ACT_LPF = 8'h10;
   localparam logic [7:0] OFF_TOT_LPF = 8'h14;
   localparam logic [7:0] OFF_LINE_PD = 8'h18;
   localparam logic [7:0] OFF_VBP = 8'h1C;
   localparam logic [7:0] OFF_VFP = 8'h20;
   localparam logic [7:0] OFF_BLK_LEN = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [7:0] OFF_BLK_BASE = 8'h40;
   localparam logic [7:0] OFF_BLK_END = 8'h80;
   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   localparam int CTRL_EN = 0;
   localparam int CTRL_FIXED = 1;
   localparam int CTRL_INV = 2;
   localparam int CTRL_BARS_LO = 4;
   localparam int CSI_VC_LO = 6;
   localparam int STAT_LINE_LO = 16;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [1:0] RST_BAR_SEL = 2'h3;
   localparam logic [5:0] RST_DT = 6'h24;
   localparam logic [15:0] RST_LINE_SIZE = 16'h0040;
   localparam logic [15:0] RST_BAR_SIZE = 16'h0008;
   localparam logic [15:0] RST_ACT_LPF = 16'h0004;
   localparam logic [15:0] RST_TOT_LPF = 16'h0008;
   localparam logic [15:0] RST_LINE_PD = 16'h0064;
   localparam logic [4:0] RST_BLK_LEN = 5'h03;
   // ------------------------------------------------------------
   // Bus answers and packet codes
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [5:0] DT_FRAME_START = 6'h00;
   localparam logic [5:0] DT_FRAME_END = 6'h01;
   localparam logic [7:0] REF_COLOUR [8] = '{8'hAA, 8'h33, 8'hF0, 8'h7F,
      8'h55, 8'hCC, 8'h0F, 8'h80};
   // ------------------------------------------------------------
   // Timing: line period unit in core clock cycles
   // ------------------------------------------------------------
   localparam int LINE_UNIT_NS = 10;
   localparam int CORE_CLK_MHZ = 200;
   localparam int UNIT_CYC_RAW = (LINE_UNIT_NS * CORE_CLK_MHZ) / 1000;
   localparam int UNIT_CYC = (UNIT_CYC_RAW < 1) ? 1 : UNIT_CYC_RAW;
   typedef enum logic [1:0] {ST_WAIT, ST_FS, ST_LINE, ST_FE} cvtpg_state_t;
endpackage

// file: design/cvtpg_top.sv
/*
 CSI-2 video test pattern generator: AXI4-Lite register slave, line
 timer, frame sequencer and byte-wide packet source for the CSI-2
 transmitter. Assumes the transmitter wraps each beat group into a
 packet and applies back-pressure through tx_ready.
*/
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module cvtpg_top
#(
   parameter int ADDR_W = 8,
   parameter int BLK_MAX = 16
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic tx_first,
   output logic tx_last,
   output logic tx_long,
   output logic [5:0] tx_dt,
   output logic [1:0] tx_vc,
   output logic [15:0] tx_wc,
   output logic [7:0] tx_data
);
   import cvtpg_pkg::*;

   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // Configuration storage
   // ------------------------------------------------------------
   logic en_q, fixed_q, inv_q;
   logic [1:0] bar_sel_q, vc_q;
   logic [5:0] dt_q;
   logic [15:0] line_size_q, bytes_per_bar_q, act_lpf_q, tot_lpf_q;
   logic [15:0] line_period_count_q, vbp_q, vfp_q, line_idx_q;
   logic [4:0] blk_len_q;
   logic [7:0] blk_q [BLK_MAX];
   logic in_frame_q;

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q, rdata_q, wr_val;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [32:0] wr_cur, rd_cur;
   logic wr_go;

   // Hit flag in bit 32, read value below; reserved bits read zero
   function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'h0};
      reg_read = {1'b1, 32'h0};
      if (w >= OFF_BLK_BASE && w < OFF_BLK_END)
         reg_read[7:0] = blk_q[w[5:2]];
      else
         case (w)
            OFF_CTRL: reg_read[31:0] = {26'h0, bar_sel_q, 1'b0, inv_q,
               fixed_q, en_q};
            OFF_CSI: reg_read[7:0] = {vc_q, dt_q};
            OFF_LINE_SIZE: reg_read[15:0] = line_size_q;
            OFF_BAR_SIZE: reg_read[15:0] = bytes_per_bar_q;
            OFF_ACT_LPF: reg_read[15:0] = act_lpf_q;
            OFF_TOT_LPF: reg_read[15:0] = tot_lpf_q;
            OFF_LINE_PD: reg_read[15:0] = line_period_count_q;
            OFF_VBP: reg_read[15:0] = vbp_q;
            OFF_VFP: reg_read[15:0] = vfp_q;
            OFF_BLK_LEN: reg_read[4:0] = blk_len_q;
            OFF_STATUS: reg_read[31:0] = {line_idx_q, 15'h0, in_frame_q};
            default: reg_read = 33'h0;
         endcase
   endfunction

   // Address and data may arrive in either order; a response blocks both
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Byte lanes merge into the current contents; a process, not an assign,
   // so that register changes seen inside the decoder also wake it
   always_comb
   begin
      wr_cur = reg_read(aw_addr_q);
      rd_cur = reg_read(s_axi_araddr);
      for (int i = 0; i < 4; i++)
         wr_val[i*8 +: 8] = w_strb_q[i] ? w_data_q[i*8 +: 8] :
            wr_cur[i*8 +: 8];
   end

   // Write channel handshakes and response
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_cur[32] ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_cur[31:0];
         rresp_q <= rd_cur[32] ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // Pattern and frame settings; the same dimensions serve both modes
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         en_q <= 1'b0;
         fixed_q <= 1'b0;
         inv_q <= 1'b0;
         bar_sel_q <= RST_BAR_SEL;
         dt_q <= RST_DT;
         vc_q <= 2'h0;
         line_size_q <= RST_LINE_SIZE;
         bytes_per_bar_q <= RST_BAR_SIZE;
         act_lpf_q <= RST_ACT_LPF;
         tot_lpf_q <= RST_TOT_LPF;
         line_period_count_q <= RST_LINE_PD;
         vbp_q <= 16'h0;
         vfp_q <= 16'h0;
         blk_len_q <= RST_BLK_LEN;
      end
      else if (wr_go)
         case ({aw_addr_q[7:2], 2'h0})
            OFF_CTRL:
            begin
               en_q <= wr_val[CTRL_EN];
               fixed_q <= wr_val[CTRL_FIXED];
               inv_q <= wr_val[CTRL_INV];
               bar_sel_q <= wr_val[CTRL_BARS_LO +: 2];
            end
            OFF_CSI:
            begin
               dt_q <= wr_val[5:0];
               vc_q <= wr_val[CSI_VC_LO +: 2];
            end
            OFF_LINE_SIZE: line_size_q <= wr_val[15:0];
            OFF_BAR_SIZE: bytes_per_bar_q <= wr_val[15:0];
            OFF_ACT_LPF: act_lpf_q <= wr_val[15:0];
            OFF_TOT_LPF: tot_lpf_q <= wr_val[15:0];
            OFF_LINE_PD: line_period_count_q <= wr_val[15:0];
            OFF_VBP: vbp_q <= wr_val[15:0];
            OFF_VFP: vfp_q <= wr_val[15:0];
            OFF_BLK_LEN: blk_len_q <= wr_val[4:0];
            default: ;
         endcase
   end

   // Fixed colour block bytes, one word each
   for (genvar g = 0; g < BLK_MAX; g++)
   begin : g_blk
      always_ff @(posedge core_clk)
      begin
         if (reset)
            blk_q[g] <= 8'h00;
         else if (wr_go && aw_addr_q[7:2] == OFF_BLK_BASE[7:2] + 6'(g))
            blk_q[g] <= wr_val[7:0];
      end
   end

   // ------------------------------------------------------------
   // Line timer
   // ------------------------------------------------------------
   localparam int UW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
   logic [UW-1:0] unit_q;
   logic [15:0] pd_q, pd_last;
   logic unit_end, line_end, line_start;
   assign pd_last = (line_period_count_q == 16'h0) ? 16'h0 :
      line_period_count_q - 16'h1;
   assign unit_end = unit_q == UW'(UNIT_CYC - 1);
   assign line_end = en_q && unit_end && pd_q == pd_last;
   assign line_start = en_q && unit_q == '0 && pd_q == 16'h0;

   // A zero period is taken as one unit
   always_ff @(posedge core_clk)
   begin
      if (reset || !en_q)
      begin
         unit_q <= '0;
         pd_q <= 16'h0;
         line_idx_q <= 16'h0;
      end
      else
      begin
         unit_q <= unit_end ? '0 : unit_q + UW'(1);
         if (line_end)
         begin
            pd_q <= 16'h0;
            line_idx_q <= (line_idx_q + 16'h1 >= tot_lpf_q) ? 16'h0 :
               line_idx_q + 16'h1;
         end
         else if (unit_end)
            pd_q <= pd_q + 16'h1;
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   logic [16:0] act_end, fe_line;
   logic fs_ev, act_ev, fe_ev, act_pend_q, load, line_done;
   cvtpg_state_t st_q;
   assign act_end = 17'(vbp_q) + 17'(act_lpf_q);
   assign fe_line = act_end + 17'(vfp_q);
   assign fs_ev = line_idx_q == 16'h0;
   assign act_ev = line_idx_q >= vbp_q && 17'(line_idx_q) < act_end;
   assign fe_ev = 17'(line_idx_q) == fe_line;
   assign load = !tx_valid || tx_ready;

   // Byte position state for the current line
   logic [15:0] pos_q, bar_cnt_q;
   logic [2:0] bar_idx_q, bars_m1;
   logic [3:0] blk_pos_q;
   logic [7:0] ref_byte, fix_byte;
   assign bars_m1 = 3'((4'h1 << bar_sel_q) - 4'h1);
   assign line_done = pos_q + 16'h1 >= line_size_q;
   assign ref_byte = REF_COLOUR[bar_idx_q];
   assign fix_byte = blk_q[blk_pos_q] ^ {8{inv_q & bar_idx_q[0]}};

   // A line start while the previous line is still draining is dropped
   always_ff @(posedge core_clk)
   begin
      if (reset || !en_q)
      begin
         st_q <= ST_WAIT;
         act_pend_q <= 1'b0;
         in_frame_q <= 1'b0;
      end
      else
         case (st_q)
            ST_WAIT:
               if (line_start)
               begin
                  act_pend_q <= fs_ev && act_ev;
                  if (fs_ev)
                     st_q <= ST_FS;
                  else if (act_ev)
                     st_q <= ST_LINE;
                  else if (fe_ev && in_frame_q)
                     st_q <= ST_FE;
               end
            ST_FS:
               if (load)
               begin
                  in_frame_q <= 1'b1;
                  st_q <= act_pend_q ? ST_LINE : ST_WAIT;
               end
            ST_LINE:
               if (load && line_done)
                  st_q <= ST_WAIT;
            ST_FE:
               if (load)
               begin
                  in_frame_q <= 1'b0;
                  st_q <= ST_WAIT;
               end
            default: st_q <= ST_WAIT;
         endcase
   end

   // Bar and block walk; the last bar never advances, absorbing the rest
   always_ff @(posedge core_clk)
   begin
      if (reset || st_q != ST_LINE)
      begin
         pos_q <= 16'h0;
         bar_cnt_q <= 16'h0;
         bar_idx_q <= 3'h0;
         blk_pos_q <= 4'h0;
      end
      else if (load)
      begin
         pos_q <= pos_q + 16'h1;
         if (bar_cnt_q + 16'h1 >= bytes_per_bar_q && bar_idx_q != bars_m1)
         begin
            bar_cnt_q <= 16'h0;
            bar_idx_q <= bar_idx_q + 3'h1;
         end
         else
            bar_cnt_q <= bar_cnt_q + 16'h1;
         blk_pos_q <= (5'(blk_pos_q) + 5'h1 >= blk_len_q) ? 4'h0 :
            blk_pos_q + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Packet output to the transmitter
   // ------------------------------------------------------------
   logic [2:0] tx_bar_q;
   logic [15:0] tx_pos_q;
   logic [7:0] tx_exp_q;

   // Beats hold until taken; short packets are single beats
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         tx_valid <= 1'b0;
         tx_first <= 1'b0;
         tx_last <= 1'b0;
         tx_long <= 1'b0;
         tx_dt <= 6'h0;
         tx_vc <= 2'h0;
         tx_wc <= 16'h0;
         tx_data <= 8'h00;
         tx_bar_q <= 3'h0;
         tx_pos_q <= 16'h0;
         tx_exp_q <= 8'h00;
      end
      else if (load)
      begin
         tx_valid <= st_q != ST_WAIT && en_q;
         tx_first <= st_q != ST_LINE || pos_q == 16'h0;
         tx_last <= st_q != ST_LINE || line_done;
         tx_long <= st_q == ST_LINE;
         tx_vc <= vc_q;
         tx_bar_q <= bar_idx_q;
         tx_pos_q <= pos_q;
         tx_exp_q <= fix_byte;
         case (st_q)
            ST_FS: tx_dt <= DT_FRAME_START;
            ST_FE: tx_dt <= DT_FRAME_END;
            default: tx_dt <= dt_q;
         endcase
         tx_wc <= (st_q == ST_LINE) ? line_size_q : 16'h0;
         if (st_q == ST_LINE)
            tx_data <= fixed_q ? fix_byte : ref_byte;
         else
            tx_data <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_REF_BYTES: assert property (
      tx_valid && tx_long && !fixed_q |-> tx_data == REF_COLOUR[tx_bar_q])
      else $error("reference bar byte wrong");
   AST_EIGHTH_BAR: assert property (
      tx_valid && tx_long && !fixed_q && tx_bar_q == 3'h7
      |-> tx_data == 8'h80)
      else $error("eighth bar not 0x80");
   AST_BAR_RANGE: assert property (
      tx_valid && tx_long |-> tx_bar_q <= bars_m1)
      else $error("bar index beyond bar count");
   AST_LINE_LEN: assert property (
      tx_valid && tx_long && tx_last |-> tx_pos_q == line_size_q - 16'h1)
      else $error("long packet length wrong");
   AST_WORD_COUNT: assert property (
      tx_valid && tx_long && tx_first
      |-> tx_wc == line_size_q && tx_dt == dt_q && tx_vc == vc_q)
      else $error("packet header fields wrong");
   AST_HOLD: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
         && $stable(tx_first))
      else $error("beat changed before taken");
   AST_FIXED: assert property (
      tx_valid && tx_long && fixed_q |-> tx_data == tx_exp_q)
      else $error("fixed colour byte wrong");
   AST_UNIT: assert property (
      line_end ##1 en_q |-> line_start ##1 !line_start)
      else $error("line period unit wrong");
   AST_ACTIVE: assert property (
      st_q == ST_WAIT && line_start && !fs_ev && act_ev |=> st_q == ST_LINE)
      else $error("active line not started");
   AST_BRESP: assert property (
      wr_go && !wr_cur[32] |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("write answer missing");
endmodule

// file: tb/cvtpg_tx_model.sv
/*
 Behavioural CSI-2 transmitter: takes beats under a random ready and logs
 every beat and the cycle at which each packet was first offered.
 Assumes the generator holds a beat steady while ready is low.
*/
`timescale 1ns/1ps
module cvtpg_tx_model
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic tx_first,
   input wire logic tx_last,
   input wire logic tx_long,
   input wire logic [5:0] tx_dt,
   input wire logic [1:0] tx_vc,
   input wire logic [15:0] tx_wc,
   input wire logic [7:0] tx_data
);
   logic [34:0] beats [$];
   int unsigned stamps [$];
   int unsigned cyc = 0;
   logic held_q = 1'b0;
   logic stall_q = 1'b0;

   assign tx_ready = !stall_q;

   // Stall one cycle in four so the source must hold its beat
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      held_q <= tx_valid && !tx_ready;
      stall_q <= !reset && ($urandom_range(3) == 0);
      if (!reset && tx_valid && tx_first && !held_q)
         stamps.push_back(cyc);
      if (!reset && tx_valid && tx_ready)
         beats.push_back({tx_first, tx_last, tx_long, tx_dt, tx_vc,
            tx_wc, tx_data});
   end
endmodule

// file: tb/testbench.sv
/*
 Self-checking bench for the pattern generator: AXI4-Lite master tasks,
 register checks, and five pattern cases checked beat by beat and by time.
 Assumes the transmitter model in cvtpg_tx_model.
*/
`timescale 1ns/1ps
module testbench;
   import cvtpg_pkg::*;
   localparam int LIMIT = 20000;
   localparam int PD = 40;
   // Per case: control bits, line bytes, bar bytes (block multiples in cases 0 to 2), block
   localparam logic [7:0] CTL [5] = '{8'h30, 8'h20, 8'h00, 8'h16, 8'h32};
   localparam int LN [5] = '{26, 27, 9, 20, 28};
   localparam int BR [5] = '{3, 6, 3, 6, 3};
   localparam int BL [5] = '{3, 3, 3, 5, 16};
   localparam logic [7:0] RA [11] = '{OFF_CTRL, OFF_CSI, OFF_LINE_SIZE,
      OFF_BAR_SIZE, OFF_ACT_LPF, OFF_TOT_LPF, OFF_LINE_PD, OFF_VBP, OFF_VFP,
      OFF_BLK_LEN, OFF_BLK_BASE};
   localparam logic [31:0] RV [11] = '{32'h30, 32'h24, 32'h40, 32'h8, 32'h4,
      32'h8, 32'h64, 32'h0, 32'h0, 32'h3, 32'h0};
   logic core_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_valid, tx_ready;
   logic tx_first, tx_last, tx_long;
   logic [7:0] s_axi_awaddr, s_axi_araddr, tx_data;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, tx_vc;
   logic [5:0] tx_dt;
   logic [15:0] tx_wc;
   logic [7:0] blk [16];
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;

   cvtpg_top #(.ADDR_W(8), .BLK_MAX(16)) dut (.core_clk, .reset,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .tx_valid, .tx_ready, .tx_first, .tx_last, .tx_long,
      .tx_dt, .tx_vc, .tx_wc, .tx_data);
   cvtpg_tx_model sink (.core_clk, .reset, .tx_valid, .tx_ready, .tx_first,
      .tx_last, .tx_long, .tx_dt, .tx_vc, .tx_wc, .tx_data);

   // 200 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Hang guard: a run this long means a handshake never came back
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         n_errors++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask

   // Ready is looked at on the falling edge, where it already shows what
   // the next rising edge will sample
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s, output logic [1:0] resp);
      logic ad, wd, ta, tw;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(negedge core_clk);
         ta = s_axi_awready && !ad;
         tw = s_axi_wready && !wd;
         @(posedge core_clk);
         if (ta === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (tw === 1'b1)
            s_axi_wvalid <= 1'b0;
         ad = ad || (ta === 1'b1);
         wd = wd || (tw === 1'b1);
      end
      do
      begin
         @(negedge core_clk);
         ta = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge core_clk);
      end while (ta !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] resp);
      logic t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge core_clk);
         t = s_axi_arready;
         @(posedge core_clk);
      end while (t !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
      begin
         @(negedge core_clk);
         t = s_axi_rvalid;
         v = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge core_clk);
      end while (t !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic set(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] r;
      wr(a, v, 4'hF, r);
      check(32'(r), 32'(RESP_OKAY), "bresp");
   endtask

   // Expected payload byte i of case c
   function automatic logic [31:0] exb(input int c, input int i);
      int k;
      logic [7:0] v;
      k = i / BR[c];
      if (k > (1 << CTL[c][5:4]) - 1)
         k = (1 << CTL[c][5:4]) - 1;
      v = CTL[c][1] ? blk[i % BL[c]] : REF_COLOUR[k];
      if (CTL[c][1] && CTL[c][2] && k[0])
         v = ~v;
      return {24'h0, v};
   endfunction

   task automatic line_check(input int c, input int a, input int dt,
      input int vc);
      logic [34:0] b;
      logic [31:0] h;
      for (int i = 0; i < LN[c]; i++)
      begin
         b = sink.beats[1 + a * LN[c] + i];
         h = {5'h0, i == 0, i == LN[c] - 1, 1'b1, 6'(dt), 2'(vc), 16'(LN[c])};
         check(32'(b[34:8]), h, "head");
         check(32'(b[7:0]), exb(c, i), "byte");
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [31:0] v;
      logic [1:0] r;
      int vbp, vfp, act, tot, dt, vc, t0;
      void'($urandom(24));
      reset = 1'b1;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 11; i++)
      begin
         rd(RA[i], v, r);
         check(v, RV[i], "reset value");
      end
      rd(8'h2C, v, r);
      check(32'(r), 32'(RESP_SLVERR), "unmapped read");
      wr(8'h30, 32'h1, 4'hF, r);
      check(32'(r), 32'(RESP_SLVERR), "unmapped write");
      wr(OFF_LINE_SIZE, 32'h1234, 4'h1, r);
      rd(OFF_LINE_SIZE, v, r);
      check(v, 32'h34, "byte lane");
      for (int c = 0; c < 5; c++)
      begin
         vbp = $urandom_range(2, 1);
         vfp = $urandom_range(2, 0);
         act = $urandom_range(3, 1);
         tot = vbp + act + vfp + 1 + $urandom_range(2, 0);
         dt = $urandom_range(63, 16);
         vc = $urandom_range(3, 0);
         for (int i = 0; i < 16; i++)
         begin
            blk[i] = 8'($urandom);
            set(8'(OFF_BLK_BASE + 4 * i), 32'(blk[i]));
         end
         set(OFF_CSI, 32'(dt + vc * 64));
         set(OFF_LINE_SIZE, LN[c]);
         set(OFF_BAR_SIZE, BR[c]);
         set(OFF_ACT_LPF, act);
         set(OFF_TOT_LPF, tot);
         set(OFF_LINE_PD, PD);
         set(OFF_VBP, vbp);
         set(OFF_VFP, vfp);
         set(OFF_BLK_LEN, BL[c]);
         sink.beats.delete();
         sink.stamps.delete();
         set(OFF_CTRL, {24'h0, CTL[c] | 8'h01});
         while (sink.stamps.size() < act + 3)
            @(posedge core_clk);
         set(OFF_CTRL, 32'h0);
         t0 = sink.stamps[0];
         v = {5'h0, 3'b110, DT_FRAME_START, 2'(vc), 16'h0};
         check(32'(sink.beats[0][34:8]), v, "start");
         for (int a = 0; a < act; a++)
         begin
            v = (vbp + a) * PD * UNIT_CYC;
            check(sink.stamps[a + 1] - t0, v, "line");
            line_check(c, a, dt, vc);
         end
         v = {5'h0, 3'b110, DT_FRAME_END, 2'(vc), 16'h0};
         r = 2'h0;
         check(32'(sink.beats[1 + act * LN[c]][34:8]), v, "end");
         v = (vbp + act + vfp) * PD * UNIT_CYC;
         check(sink.stamps[act + 1] - t0, v, "end time");
         v = tot * PD * UNIT_CYC;
         check(sink.stamps[act + 2] - t0, v, "frame");
      end
      stop_test();
   end
endmodule
